// file: src/lcm_pkg.sv
// Constants and types for the LCD memory configuration register block
// Operation
// - Any configuration write restarts display timing and blanks the display.
// - In indirect mode, a configuration write ends power save.
// - Init command parameter bytes load registers 00h through 07h in order.
// - Compensation bit 5 is inverted: zero enables, one disables.
// - With compensation on, text sits one pixel row below graphics.
// - Fine scroll shifts text right by 1 to 7 pixels.
// - Bit 3 low drives a single panel, high a dual panel.
// - Single panel: layer line counts 00h up to frame height; block four unused.
// - Bit 2 low gives 8-pixel glyphs, high gives 16-pixel glyphs from glyph RAM; ROM glyphs stay 8 rows.
// - Bit 0 low selects fixed glyph ROM, high the user glyph RAM.
// - Fixed glyph ROM holds 160 characters of 5x7 pixels.
// - Glyph RAM holds 256 characters, only 64 of 8x8 while ROM used.
// - Reserved bit 4 resets to one, reserved bit 1 to zero.
package lcm_pkg;

  localparam logic [15:0] MEM_PANEL_CFG_ADDR = 16'h8000;
  localparam logic [15:0] SYS_REG_LAST_ADDR  = 16'h8007;
  localparam logic [7:0]  CFG_RESET          = 8'h10;
  localparam logic [7:0]  CFG_WR_MASK        = 8'h3F;
  localparam logic [7:0]  READ_ZERO          = 8'h00;

  localparam int CFG_SRC_BIT  = 0;
  localparam int CFG_TALL_BIT = 2;
  localparam int CFG_DUAL_BIT = 3;
  localparam int CFG_COMP_BIT = 5;

  localparam logic [2:0] SYS_REG_LAST   = 3'h7;
  localparam logic [2:0] FRAME_HT_INDEX = 3'h5;
  localparam logic [2:0] CFG_INDEX      = 3'h0;

  // Init command opcode; value arbitrary
  localparam logic [7:0] INIT_CMD_CODE = 8'hA5;

  localparam logic [7:0]  ROM_CHAR_COUNT      = 8'hA0;
  localparam logic [7:0]  RAM_CHAR_LIMIT_ROM  = 8'h40;
  localparam logic [2:0]  GLYPH_ROM_ROWS      = 3'h7;
  localparam logic [3:0]  GLYPH_ROWS_SHORT    = 4'h7;
  localparam logic [3:0]  GLYPH_ROWS_TALL     = 4'hF;
  localparam logic [2:0]  SCROLL_MAX          = 3'h7;

  typedef enum logic {
    LCM_IDLE,
    LCM_PARAM
  } lcm_seq_type;

endpackage : lcm_pkg

// file: src/lcm_sys_mem.sv
// Byte store for system control registers 01h to 07h
`timescale 1ns/1ps
module lcm_sys_mem
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_index,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [2:0] rd_index,
  output logic      [7:0] rd_data_ff,
  // Frame height copy
  output logic      [7:0] frame_height_ff
);
  import lcm_pkg::*;

  logic [7:0] mem_ff [8];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem_ff[wr_index] <= wr_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rd_data_ff <= READ_ZERO;
    else
      rd_data_ff <= mem_ff[rd_index];
  end

  // Kept apart so the line count checks never wait on the read port
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      frame_height_ff <= READ_ZERO;
    else if (wr_en && wr_index == FRAME_HT_INDEX)
      frame_height_ff <= wr_data;
  end

endmodule : lcm_sys_mem

// file: src/lcm_glyph_map.sv
// Glyph fetch address mapper for the text layer
`timescale 1ns/1ps
module lcm_glyph_map
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        comp_active,
  input  wire logic        glyph_tall,
  input  wire logic        glyph_from_ram,
  input  wire logic [2:0]  fine_scroll,
  input  wire logic [15:0] user_glyph_base,
  // Lookup request
  input  wire logic [7:0]  char_code,
  input  wire logic [3:0]  screen_row,
  input  wire logic [2:0]  screen_col,
  // Lookup result
  output logic      [15:0] glyph_addr_ff,
  output logic      [2:0]  glyph_col_ff,
  output logic             glyph_in_rom_ff,
  output logic             glyph_blank_ff
);
  import lcm_pkg::*;

  logic [3:0]  row_max;
  logic [3:0]  text_row;
  logic        row_blank;
  logic        col_blank;
  logic        code_bad;
  logic        rom_row_bad;
  logic [15:0] rom_addr;
  logic [15:0] ram_addr;

  assign row_max     = glyph_tall ? GLYPH_ROWS_TALL : GLYPH_ROWS_SHORT;
  // Text drops one row below the background layer
  assign row_blank   = comp_active && screen_row == 4'h0;
  assign text_row    = comp_active ? screen_row - 4'h1 : screen_row;
  // Scroll of zero is a no-op; values 1 to 7 push text right
  assign col_blank   = screen_col < fine_scroll;
  assign rom_row_bad = text_row > {1'b0, GLYPH_ROM_ROWS};
  assign code_bad    = glyph_from_ram ? 1'b0
                     : char_code >= ROM_CHAR_COUNT;
  assign rom_addr    = {5'h00, char_code, text_row[2:0]};
  assign ram_addr    = user_glyph_base
                     + (glyph_tall ? {4'h0, char_code, text_row}
                                   : {5'h00, char_code, text_row[2:0]});

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      glyph_addr_ff   <= 16'h0000;
      glyph_col_ff    <= 3'h0;
      glyph_in_rom_ff <= 1'b1;
      glyph_blank_ff  <= 1'b1;
    end
    else
    begin
      glyph_addr_ff   <= glyph_from_ram ? ram_addr : rom_addr;
      glyph_col_ff    <= screen_col - fine_scroll;
      glyph_in_rom_ff <= ~glyph_from_ram;
      glyph_blank_ff  <= row_blank || col_blank || code_bad
                      || text_row > row_max
                      || (!glyph_from_ram && rom_row_bad);
    end
  end

endmodule : lcm_glyph_map

// file: src/lcm_cfg_top.sv
// Memory and panel configuration register with host access paths
`timescale 1ns/1ps
module lcm_cfg_top
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Host pins, asynchronous to ref_clk
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic        host_cmd_sel,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wr_data,
  output logic      [7:0]  host_rd_data_ff,
  output logic             host_rd_valid_ff,
  // Mode strap level
  input  wire logic        indirect_mode,
  // Neighbouring logic, same clock
  input  wire logic        display_on,
  input  wire logic        power_save_enter,
  input  wire logic [2:0]  fine_scroll,
  input  wire logic [15:0] user_glyph_base,
  input  wire logic [7:0]  layer_one_line_count,
  input  wire logic [7:0]  layer_two_line_count,
  // Configuration outputs
  output logic             timing_restart_ff,
  output logic             display_enable_ff,
  output logic             power_save_ff,
  output logic             origin_compensation,
  output logic             dual_panel,
  output logic             fourth_block_start_valid,
  output logic             glyph_height_select,
  output logic             glyph_source_select,
  output logic             layer_one_count_ok_ff,
  output logic             layer_two_count_ok_ff,
  // Glyph lookup
  input  wire logic [7:0]  char_code,
  input  wire logic [3:0]  screen_row,
  input  wire logic [2:0]  screen_col,
  output logic      [15:0] glyph_addr_ff,
  output logic      [2:0]  glyph_col_ff,
  output logic             glyph_in_rom_ff,
  output logic             glyph_blank_ff
);
  import lcm_pkg::*;

  // Settled when the second and third stages agree
  function automatic logic stage_edge(input logic [2:0] s,
                                      input logic       lvl);
    stage_edge = (s[1] == s[2]) && (s[2] != lvl) && s[2];
  endfunction : stage_edge

  function automatic logic count_ok(input logic [7:0] cnt,
                                    input logic [7:0] fh,
                                    input logic       dual);
    logic [8:0] half;
    half = ({1'b0, fh} + 9'h001) >> 1;
    if (dual)
      count_ok = {1'b0, cnt} == half - 9'h001;
    else
      count_ok = cnt <= fh;
  endfunction : count_ok

  logic [2:0]  wr_sync_ff;
  logic [2:0]  rd_sync_ff;
  logic [2:0]  mode_sync_ff;
  logic        wr_lvl_ff;
  logic        rd_lvl_ff;
  logic        indirect_ff;
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic [2:0]  param_idx_ff;
  logic [2:0]  nxt_param_idx;
  lcm_seq_type seq_ff;
  lcm_seq_type nxt_seq;
  logic        rd_pend_ff;
  logic        rd_cfg_ff;
  logic        rd_mem_ff;
  logic [7:0]  frame_height;
  logic [7:0]  mem_rd_data;

  logic        wr_seen;
  logic        rd_seen;
  logic        addr_cfg;
  logic        addr_sys;
  logic        direct_wr;
  logic        init_cmd;
  logic        param_wr;
  logic        cfg_wr;
  logic        mem_wr;
  logic [2:0]  wr_index;
  logic [7:0]  rd_mux;

  // Pin sampling; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_sync_ff   <= 3'h0;
      rd_sync_ff   <= 3'h0;
      mode_sync_ff <= 3'h0;
    end
    else
    begin
      wr_sync_ff   <= {wr_sync_ff[1:0], host_wr};
      rd_sync_ff   <= {rd_sync_ff[1:0], host_rd};
      mode_sync_ff <= {mode_sync_ff[1:0], indirect_mode};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_lvl_ff   <= 1'b0;
      rd_lvl_ff   <= 1'b0;
      indirect_ff <= 1'b0;
    end
    else
    begin
      if (wr_sync_ff[1] == wr_sync_ff[2])
        wr_lvl_ff <= wr_sync_ff[2];
      if (rd_sync_ff[1] == rd_sync_ff[2])
        rd_lvl_ff <= rd_sync_ff[2];
      if (mode_sync_ff[1] == mode_sync_ff[2])
        indirect_ff <= mode_sync_ff[2];
    end
  end

  // Address and data must be stable for the whole strobe
  assign wr_seen   = stage_edge(wr_sync_ff, wr_lvl_ff);
  assign rd_seen   = stage_edge(rd_sync_ff, rd_lvl_ff);
  assign addr_cfg  = host_addr == MEM_PANEL_CFG_ADDR;
  assign addr_sys  = host_addr >= MEM_PANEL_CFG_ADDR
                  && host_addr <= SYS_REG_LAST_ADDR;
  assign direct_wr = wr_seen && !indirect_ff && addr_sys;
  assign init_cmd  = wr_seen && indirect_ff && host_cmd_sel
                  && host_wr_data == INIT_CMD_CODE;
  assign param_wr  = wr_seen && indirect_ff && !host_cmd_sel
                  && seq_ff == LCM_PARAM;
  assign wr_index  = param_wr ? param_idx_ff : host_addr[2:0];
  assign cfg_wr    = (direct_wr && addr_cfg)
                  || (param_wr && param_idx_ff == CFG_INDEX);
  assign mem_wr    = (direct_wr || param_wr) && wr_index != CFG_INDEX;

  // Parameter sequencer for the init command
  always_comb
  begin
    nxt_seq       = seq_ff;
    nxt_param_idx = param_idx_ff;
    case (seq_ff)
      LCM_IDLE:
      begin
        if (init_cmd)
        begin
          nxt_seq       = LCM_PARAM;
          nxt_param_idx = CFG_INDEX;
        end
      end
      LCM_PARAM:
      begin
        if (wr_seen && indirect_ff && host_cmd_sel)
        begin
          // Another command aborts a short parameter list
          nxt_seq       = init_cmd ? LCM_PARAM : LCM_IDLE;
          nxt_param_idx = CFG_INDEX;
        end
        else if (param_wr)
        begin
          nxt_param_idx = param_idx_ff + 3'h1;
          if (param_idx_ff == SYS_REG_LAST)
            nxt_seq = LCM_IDLE;
        end
      end
      default:
      begin
        nxt_seq       = LCM_IDLE;
        nxt_param_idx = CFG_INDEX;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !indirect_ff)
    begin
      seq_ff       <= LCM_IDLE;
      param_idx_ff <= CFG_INDEX;
    end
    else
    begin
      seq_ff       <= nxt_seq;
      param_idx_ff <= nxt_param_idx;
    end
  end

  // Top bits forced low; reserved bits kept as written
  assign nxt_cfg = host_wr_data & CFG_WR_MASK;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_ff <= CFG_RESET;
    else if (cfg_wr)
      cfg_ff <= nxt_cfg;
  end

  // Write side effects; the write wins over a same-cycle enable
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timing_restart_ff <= 1'b0;
      display_enable_ff <= 1'b0;
      power_save_ff     <= 1'b0;
    end
    else
    begin
      timing_restart_ff <= cfg_wr;
      if (cfg_wr)
        display_enable_ff <= 1'b0;
      else if (display_on)
        display_enable_ff <= 1'b1;
      if (cfg_wr && indirect_ff)
        power_save_ff <= 1'b0;
      else if (power_save_enter)
        power_save_ff <= 1'b1;
    end
  end

  assign origin_compensation      = ~cfg_ff[CFG_COMP_BIT];
  assign dual_panel               = cfg_ff[CFG_DUAL_BIT];
  assign fourth_block_start_valid = cfg_ff[CFG_DUAL_BIT];
  assign glyph_height_select      = cfg_ff[CFG_TALL_BIT];
  assign glyph_source_select      = cfg_ff[CFG_SRC_BIT];

  lcm_sys_mem u_sys_mem
  (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .wr_en           (mem_wr),
    .wr_index        (wr_index),
    .wr_data         (host_wr_data),
    .rd_index        (host_addr[2:0]),
    .rd_data_ff      (mem_rd_data),
    .frame_height_ff (frame_height)
  );

  // Read path: the store answers one cycle after the strobe settles
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_pend_ff <= 1'b0;
      rd_cfg_ff  <= 1'b0;
      rd_mem_ff  <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= rd_seen && !indirect_ff;
      rd_cfg_ff  <= addr_cfg;
      rd_mem_ff  <= addr_sys && !addr_cfg;
    end
  end

  assign rd_mux = rd_cfg_ff ? cfg_ff
                : rd_mem_ff ? mem_rd_data
                : READ_ZERO;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      host_rd_data_ff  <= READ_ZERO;
      host_rd_valid_ff <= 1'b0;
    end
    else
    begin
      host_rd_valid_ff <= rd_pend_ff;
      if (rd_pend_ff)
        host_rd_data_ff <= rd_mux;
    end
  end

  // Line count range checks follow the panel organisation
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      layer_one_count_ok_ff <= 1'b1;
      layer_two_count_ok_ff <= 1'b1;
    end
    else
    begin
      layer_one_count_ok_ff <= count_ok(layer_one_line_count,
                                        frame_height,
                                        dual_panel);
      layer_two_count_ok_ff <= count_ok(layer_two_line_count,
                                        frame_height,
                                        dual_panel);
    end
  end

  lcm_glyph_map u_glyph_map
  (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .comp_active     (origin_compensation),
    .glyph_tall      (glyph_height_select),
    .glyph_from_ram  (glyph_source_select),
    .fine_scroll     (fine_scroll),
    .user_glyph_base (user_glyph_base),
    .char_code       (char_code),
    .screen_row      (screen_row),
    .screen_col      (screen_col),
    .glyph_addr_ff   (glyph_addr_ff),
    .glyph_col_ff    (glyph_col_ff),
    .glyph_in_rom_ff (glyph_in_rom_ff),
    .glyph_blank_ff  (glyph_blank_ff)
  );

endmodule : lcm_cfg_top

// file: sim/lcm_checker.sv
// Port checks for the configuration register block
`timescale 1ns/1ps
module lcm_checker
  import lcm_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Inputs seen
  input wire logic       indirect_mode,
  input wire logic [2:0] fine_scroll,
  input wire logic [7:0] char_code,
  input wire logic [3:0] screen_row,
  input wire logic [2:0] screen_col,
  // Outputs seen
  input wire logic       host_rd_valid_ff,
  input wire logic       timing_restart_ff,
  input wire logic       display_enable_ff,
  input wire logic       power_save_ff,
  input wire logic       origin_compensation,
  input wire logic       dual_panel,
  input wire logic       fourth_block_start_valid,
  input wire logic       glyph_height_select,
  input wire logic       glyph_source_select,
  input wire logic       glyph_in_rom_ff,
  input wire logic       glyph_blank_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_restart_blanks: assert property (
    timing_restart_ff |-> !display_enable_ff)
    else $error("Display still on at restart");
  a_restart_pulse: assert property (
    timing_restart_ff |=> !timing_restart_ff)
    else $error("Restart pulse too long");
  // Config moves only with a write, never on its own
  a_cfg_on_write: assert property (
    !timing_restart_ff && !$past(rst) |-> $stable({origin_compensation,
      dual_panel, glyph_height_select, glyph_source_select}))
    else $error("Config changed without restart");
  a_block_four: assert property (
    fourth_block_start_valid == dual_panel)
    else $error("Block four valid not tied to panel");
  a_power_wake: assert property (
    timing_restart_ff && indirect_mode |-> !power_save_ff)
    else $error("Power save kept after write");
  a_read_pulse: assert property (
    host_rd_valid_ff |=> !host_rd_valid_ff)
    else $error("Read valid too long");
  a_rom_range: assert property (
    !glyph_source_select && char_code >= ROM_CHAR_COUNT |=> glyph_blank_ff)
    else $error("Code past ROM not blank");
  a_source_sel: assert property (
    1'b1 |=> glyph_in_rom_ff != $past(glyph_source_select))
    else $error("Glyph source wrong");
  a_comp_row: assert property (
    origin_compensation && screen_row == 4'h0 |=> glyph_blank_ff)
    else $error("Top row not blank");
  a_scroll_blank: assert property (
    screen_col < fine_scroll |=> glyph_blank_ff)
    else $error("Scrolled column not blank");

  cover property (timing_restart_ff && indirect_mode);
  cover property (timing_restart_ff && dual_panel);
  cover property (host_rd_valid_ff);
endmodule : lcm_checker

bind lcm_cfg_top lcm_checker chk_u (.ref_clk, .rst, .indirect_mode,
  .fine_scroll, .char_code, .screen_row, .screen_col, .host_rd_valid_ff,
  .timing_restart_ff, .display_enable_ff, .power_save_ff,
  .origin_compensation, .dual_panel, .fourth_block_start_valid,
  .glyph_height_select, .glyph_source_select, .glyph_in_rom_ff,
  .glyph_blank_ff);

// file: sim/lcm_host_model.sv
// Host processor model on the parallel register pins
`timescale 1ns/1ps
module lcm_host_model
  import lcm_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Host pins
  output logic             host_wr,
  output logic             host_rd,
  output logic             host_cmd_sel,
  output logic      [15:0] host_addr,
  output logic      [7:0]  host_wr_data,
  input  wire logic [7:0]  host_rd_data_ff,
  input  wire logic        host_rd_valid_ff
);
  initial
  begin
    host_wr      = 1'b0;
    host_rd      = 1'b0;
    host_cmd_sel = 1'b0;
    host_addr    = 16'h0000;
    host_wr_data = 8'h00;
  end

  // Released lines flip, so stale values never pass
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d,
                        input logic c);
    @(posedge ref_clk);
    host_addr    <= a;
    host_wr_data <= d;
    host_cmd_sel <= c;
    host_wr      <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_wr      <= 1'b0;
    @(posedge ref_clk);
    host_addr    <= ~a;
    host_wr_data <= ~d;
    repeat (3) @(posedge ref_clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d,
                        output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge ref_clk);
    host_addr <= a;
    host_rd   <= 1'b1;
    for (int n = 0; n < 12 && !ok; n++)
    begin
      @(posedge ref_clk);
      ok = (host_rd_valid_ff === 1'b1);
      d  = host_rd_data_ff;
    end
    host_rd   <= 1'b0;
    @(posedge ref_clk);
    host_addr <= ~a;
    repeat (3) @(posedge ref_clk);
  endtask : bus_rd

  task automatic init_seq(input logic [7:0] p [8]);
    bus_wr(16'h0000, INIT_CMD_CODE, 1'b1);
    foreach (p[i])
      bus_wr(16'h0000, p[i], 1'b0);
  endtask : init_seq
endmodule : lcm_host_model

// file: sim/tb_top.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module tb_top;
  import lcm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        host_wr, host_rd, host_cmd_sel, host_rd_valid_ff;
  logic [15:0] host_addr, user_glyph_base, glyph_addr_ff;
  logic [7:0]  host_wr_data, host_rd_data_ff, char_code;
  logic [7:0]  layer_one_line_count, layer_two_line_count;
  logic        indirect_mode, display_on, power_save_enter;
  logic [2:0]  fine_scroll, screen_col, glyph_col_ff;
  logic [3:0]  screen_row;
  logic        timing_restart_ff, display_enable_ff, power_save_ff;
  logic        origin_compensation, dual_panel, fourth_block_start_valid;
  logic        glyph_height_select, glyph_source_select;
  logic        layer_one_count_ok_ff, layer_two_count_ok_ff;
  logic        glyph_in_rom_ff, glyph_blank_ff, ok;
  int          err_count = 0;
  int          compares  = 0;
  int          restarts  = 0;
  int          n;
  logic [31:0] seed = 32'hF682;
  logic [7:0]  rd, cfg, fh;
  logic [7:0]  prm [8];
  logic [7:0]  gl [4] = '{8'h00, 8'h21, 8'h05, 8'h24};

  lcm_host_model host_u (.ref_clk, .host_wr, .host_rd, .host_cmd_sel,
    .host_addr, .host_wr_data, .host_rd_data_ff, .host_rd_valid_ff);
  lcm_cfg_top dut_u (.ref_clk, .rst, .host_wr, .host_rd, .host_cmd_sel,
    .host_addr, .host_wr_data, .host_rd_data_ff, .host_rd_valid_ff,
    .indirect_mode, .display_on, .power_save_enter, .fine_scroll,
    .user_glyph_base, .layer_one_line_count, .layer_two_line_count,
    .timing_restart_ff, .display_enable_ff, .power_save_ff,
    .origin_compensation, .dual_panel, .fourth_block_start_valid,
    .glyph_height_select, .glyph_source_select, .layer_one_count_ok_ff,
    .layer_two_count_ok_ff, .char_code, .screen_row, .screen_col,
    .glyph_addr_ff, .glyph_col_ff, .glyph_in_rom_ff, .glyph_blank_ff);

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (timing_restart_ff === 1'b1)
      restarts++;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic cmp(input string nm, input logic [15:0] e, s);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic finish_test;
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic rd_cmp(input logic [15:0] a, input logic [7:0] e);
    host_u.bus_rd(a, rd, ok);
    cmp("read_valid", 1'b1, ok);
    cmp("read_data", e, rd);
  endtask : rd_cmp

  task automatic chk_cfg(input logic [7:0] d);
    cmp("origin_compensation", !d[5], origin_compensation);
    cmp("dual_panel", d[3], dual_panel);
    cmp("fourth_block_valid", d[3], fourth_block_start_valid);
    cmp("glyph_height_select", d[2], glyph_height_select);
    cmp("glyph_source_select", d[0], glyph_source_select);
  endtask : chk_cfg

  task automatic lines(input logic [7:0] a, b, input logic ea, eb);
    layer_one_line_count <= a;
    layer_two_line_count <= b;
    repeat (3) @(posedge ref_clk);
    cmp("layer_one_ok", ea, layer_one_count_ok_ff);
    cmp("layer_two_ok", eb, layer_two_count_ok_ff);
  endtask : lines

  task automatic glyph(input logic [7:0] c, input logic [3:0] r,
                       input logic [2:0] col, s);
    logic [3:0]  tr;
    logic        blank;
    logic [15:0] ea;
    char_code   <= c;
    screen_row  <= r;
    screen_col  <= col;
    fine_scroll <= s;
    repeat (2) @(posedge ref_clk);
    tr    = origin_compensation ? r - 4'h1 : r;
    // Rows past the glyph height, or past the ROM rows, stay blank
    blank = (origin_compensation && r == 4'h0) || col < s ||
            (!glyph_source_select && c >= ROM_CHAR_COUNT) ||
            (tr > 4'h7 && !(glyph_source_select && glyph_height_select));
    ea    = glyph_source_select ?
            user_glyph_base + c * (glyph_height_select ? 16 : 8) + tr :
            {c, 3'h0} + tr;
    cmp("glyph_blank", blank, glyph_blank_ff);
    if (!blank)
    begin
      cmp("glyph_addr", ea, glyph_addr_ff);
      cmp("glyph_col", 3'(col - s), glyph_col_ff);
    end
    cmp("glyph_in_rom", !glyph_source_select, glyph_in_rom_ff);
  endtask : glyph

  initial
  begin
    indirect_mode        = 1'b0;
    display_on           = 1'b0;
    power_save_enter     = 1'b0;
    fine_scroll          = 3'h0;
    user_glyph_base      = 16'h0000;
    layer_one_line_count = 8'h00;
    layer_two_line_count = 8'h00;
    char_code            = 8'h00;
    screen_row           = 4'h0;
    screen_col           = 3'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd_cmp(MEM_PANEL_CFG_ADDR, CFG_RESET);
    chk_cfg(CFG_RESET);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      // Reserved bits kept zero, unused bits 7 and 6 exercised
      cfg  = (i == 0) ? 8'hED : (i == 1) ? 8'h00 : seed[7:0] & 8'hED;
      display_on <= 1'b1;
      @(posedge ref_clk);
      display_on <= 1'b0;
      @(posedge ref_clk);
      cmp("display_enable", 1'b1, display_enable_ff);
      n = restarts;
      host_u.bus_wr(MEM_PANEL_CFG_ADDR, cfg, 1'b0);
      cmp("restarts", n + 1, restarts);
      cmp("display_enable", 1'b0, display_enable_ff);
      chk_cfg(cfg);
      rd_cmp(MEM_PANEL_CFG_ADDR, cfg & CFG_WR_MASK);
    end
    n = restarts;
    host_u.bus_wr(16'h8008, 8'h2D, 1'b0);
    cmp("restarts", n, restarts);
    rd_cmp(16'h8008, READ_ZERO);
    power_save_enter <= 1'b1;
    @(posedge ref_clk);
    power_save_enter <= 1'b0;
    host_u.bus_wr(MEM_PANEL_CFG_ADDR, 8'h08, 1'b0);
    cmp("power_save", 1'b1, power_save_ff);
    fh = (seed[15:8] & 8'h7F) | 8'h01;
    host_u.bus_wr(16'h8005, fh, 1'b0);
    lines(fh >> 1, (fh >> 1) + 8'h01, 1'b1, 1'b0);
    host_u.bus_wr(MEM_PANEL_CFG_ADDR, 8'h00, 1'b0);
    lines(fh, fh + 8'h01, 1'b1, 1'b0);
    foreach (gl[j])
    begin
      host_u.bus_wr(MEM_PANEL_CFG_ADDR, gl[j], 1'b0);
      glyph(ROM_CHAR_COUNT, 4'h1, 3'h7, 3'h0);
      glyph(8'h3F, 4'h0, 3'h7, 3'h0);
      for (int k = 0; k < 8; k++)
      begin
        seed = xs(seed);
        user_glyph_base <= seed[31:16];
        glyph(seed[7:0], seed[11:8], seed[14:12], seed[18:16]);
      end
    end
    indirect_mode    <= 1'b1;
    power_save_enter <= 1'b1;
    @(posedge ref_clk);
    power_save_enter <= 1'b0;
    repeat (4) @(posedge ref_clk);
    seed = xs(seed);
    foreach (prm[i])
      prm[i] = seed[i*3 +: 8];
    prm[0] = prm[0] & 8'hED;
    n = restarts;
    host_u.init_seq(prm);
    cmp("restarts", n + 1, restarts);
    cmp("power_save", 1'b0, power_save_ff);
    chk_cfg(prm[0]);
    indirect_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 1; i < 8; i++)
      rd_cmp(MEM_PANEL_CFG_ADDR + 16'(i), prm[i]);
    finish_test();
  end
endmodule : tb_top
